// >>> rtl/bmirq_pkg.sv
package bmirq_pkg;

    // Number of shared mode/interrupt pins.
    localparam int unsigned NUM_PINS       = 4;
    // Synchroniser depth for pin inputs.
    localparam int unsigned SYNC_STAGES    = 3;
    // Operating mode value after reset and while reset is held.
    localparam logic [3:0]  MODE_RESET_VAL = 4'h0;
    // Phase generator width and value after reset.
    localparam int unsigned PHASE_W        = 2;
    localparam logic [1:0]  PHASE_RESET    = 2'h0;
    // Bit positions within the mode value.
    localparam int unsigned MODE_BIT_A     = 0;
    localparam int unsigned MODE_BIT_D     = 3;
    // Settle count at which the strap value is captured after release.
    localparam logic [2:0]  SETTLE_CYC     = 3'h5;
    // Settle counter value after reset.
    localparam logic [2:0]  SETTLE_RESET   = 3'h0;

endpackage

// >>> rtl/bmirq_pin_sync.sv
`timescale 1ns/10ps
module bmirq_pin_sync
    import bmirq_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Asynchronous active-low pin.
    input  wire logic pin_n_i,
    // Filtered, active-high request level.
    output logic      level_o
);

    logic [2:0] stage_q;
    logic       level_q;
    wire        agree;

    // A change counts once the second and third stages agree.
    assign agree   = (stage_q[1] == stage_q[2]);
    assign level_o = level_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            stage_q <= 3'h7;
            level_q <= 1'b0;
        end
        else
        begin
            stage_q <= {stage_q[1:0], pin_n_i};
            if (agree)
            begin
                level_q <= ~stage_q[2];
            end
        end
    end

endmodule

// >>> rtl/bmirq_top.sv
// Function
// (RL1) Pins active low, synchronised before use
// (RL2) Latch sixteen-way mode at reset release
// (RL3) After reset, pins are maskable interrupt requests
// (RL4) Low first pin wakes from stop standby
// (RL5) Reset holds chip and clears phase generator
// (RL6) Reset held low through power-up
// (RL7) Stable clock supplied while reset asserted
// (RL8) First pin is mode LSB, fourth MSB
`timescale 1ns/10ps
module bmirq_top
    import bmirq_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // Shared mode/interrupt pins, active low.
    input  wire logic                mode_sel0_irq0_pin_n_i,
    input  wire logic                mode_sel1_irq1_pin_n_i,
    input  wire logic                mode_sel2_irq2_pin_n_i,
    input  wire logic                mode_sel3_irq3_pin_n_i,
    // Interrupt configuration from the core.
    input  wire logic [3:0]          irq_mask_i,
    input  wire logic [3:0]          irq_edge_mode_i,
    input  wire logic [3:0]          irq_ack_i,
    // Stop standby status from the core.
    input  wire logic                stop_standby_i,
    // Mode, interrupt, wake, core reset and phase outputs.
    output logic [3:0]               operating_mode_register_o,
    output logic                     mode_valid_o,
    output logic [3:0]               irq_pending_o,
    output logic                     irq_o,
    output logic                     stop_wake_o,
    output logic                     core_reset_n_o,
    output logic [PHASE_W-1:0]       phase_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    wire  [3:0] pin_n;
    logic [3:0] req_lvl;

    assign pin_n = {mode_sel3_irq3_pin_n_i, mode_sel2_irq2_pin_n_i,
                    mode_sel1_irq1_pin_n_i, mode_sel0_irq0_pin_n_i};

    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_sync
        bmirq_pin_sync u_sync (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .pin_n_i (pin_n[g]),
            .level_o (req_lvl[g])
        ); // RL1
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode capture at reset release.

    // The synchronisers need several edges after release before they show
    // the pins, so the capture waits until a settle counter runs out.
    // Straps must therefore stay put for a few cycles after release.
    typedef enum logic [1:0]
    {
        ST_HOLD   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10
    } bmirq_state_e;

    bmirq_state_e       state_q;
    bmirq_state_e       state_d;
    logic [2:0]         settle_q;
    logic [2:0]         settle_d;
    logic               run_q;
    logic [3:0]         mode_q;
    logic [3:0]         mode_d;
    logic [3:0]         prev_lvl_q;
    logic [3:0]         pend_q;
    logic [PHASE_W-1:0] phase_q;
    wire                settled;
    wire                run_d;
    wire  [3:0]         strap_val;

    assign settled   = (settle_q == SETTLE_CYC);
    assign run_d     = (state_d == ST_RUN);
    // Pins are active low, so a low strap reads as one.
    assign strap_val = {req_lvl[MODE_BIT_D], req_lvl[2], req_lvl[1],
                        req_lvl[MODE_BIT_A]}; // RL8

    // The first edge after release already counts as a settle cycle.
    always_comb
    begin
        state_d  = state_q;
        settle_d = settle_q;
        mode_d   = mode_q;
        case (state_q)
            ST_HOLD:
            begin
                settle_d = settle_q + 3'h1;
                state_d  = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                settle_d = settle_q + 3'h1;
                if (settled)
                begin
                    mode_d  = strap_val; // RL2
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q  <= ST_HOLD;
            settle_q <= SETTLE_RESET;
            mode_q   <= MODE_RESET_VAL;
        end
        else
        begin
            state_q  <= state_d;
            settle_q <= settle_d;
            mode_q   <= mode_d;
        end
    end

    // The run flag is kept in a flop of its own so that the reset output
    // to the core is free of decode glitches.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            run_q <= 1'b0; // RL5
        end
        else
        begin
            run_q <= run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests.

    wire [3:0] fall_evt;
    wire [3:0] pend_d;

    // A falling pin is a rising active-high level.
    assign fall_evt = req_lvl & ~prev_lvl_q;
    // Edge requests are sticky; a new edge wins over an acknowledge.
    assign pend_d   = irq_edge_mode_i & ((pend_q & ~irq_ack_i) | fall_evt);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            prev_lvl_q <= 4'h0;
            pend_q     <= 4'h0;
        end
        else
        begin
            prev_lvl_q <= req_lvl;
            if (run_q)
            begin
                pend_q <= pend_d; // RL3
            end
        end
    end

    // Level requests follow the synchronised pin; nothing is requested
    // until the mode has been captured.
    wire [3:0] raw_req;

    assign raw_req = run_q ? ((irq_edge_mode_i & pend_q)
                             | (~irq_edge_mode_i & req_lvl)) : 4'h0; // RL3

    ////////////////////////////////////////////////////////////////////////
    // Phase generator.

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            phase_q <= PHASE_RESET; // RL5
        end
        else
        begin
            phase_q <= phase_q + {{(PHASE_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign operating_mode_register_o = mode_q;
    assign mode_valid_o              = run_q;
    assign irq_pending_o             = raw_req;
    assign irq_o                     = |(raw_req & irq_mask_i);
    assign stop_wake_o               = run_q && stop_standby_i
                                       && req_lvl[0]; // RL4
    assign core_reset_n_o            = run_q; // RL5
    assign phase_o                   = phase_q;

endmodule

// >>> dv/bmirq_board.sv
`timescale 1ns/10ps
module bmirq_board
(
    // Clock and pins to pull low.
    input  wire logic       clk_i,
    input  wire logic [3:0] low_i,
    // Pins, pulled up unless held low.
    output wire logic [3:0] pin_n_o
);
    // Pins follow the bench at once, so there is no race at the edge.
    assign pin_n_o = clk_i ? ~low_i : ~low_i;
endmodule

// >>> dv/bmirq_properties.sv
`timescale 1ns/10ps
module bmirq_properties
    import bmirq_pkg::*;
(
    input wire logic clk_i, rst_n_i, stop_standby_i, mode_valid_o, irq_o,
    input wire logic stop_wake_o, core_reset_n_o, mode_sel0_irq0_pin_n_i,
    input wire logic mode_sel1_irq1_pin_n_i, mode_sel2_irq2_pin_n_i,
    input wire logic mode_sel3_irq3_pin_n_i,
    input wire logic [3:0] operating_mode_register_o, irq_pending_o,
    input wire logic [PHASE_W-1:0] phase_o
);
    wire [3:0] pn = {mode_sel3_irq3_pin_n_i, mode_sel2_irq2_pin_n_i,
                     mode_sel1_irq1_pin_n_i, mode_sel0_irq0_pin_n_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    rst_hold_a: assert property ($rose(rst_n_i) |-> !core_reset_n_o
        && phase_o == PHASE_RESET) else $error("reset state");
    mode_latch_a: assert property ($rose(mode_valid_o) |->
        operating_mode_register_o == ~pn) else $error("mode");
    mode_keep_a: assert property (mode_valid_o |=>
        $stable(operating_mode_register_o)) else $error("mode moved");
    early_req_a: assert property (!mode_valid_o |-> !irq_o
        && irq_pending_o == 4'h0) else $error("early request");
    sync_delay_a: assert property ($rose(irq_pending_o[1]) |->
        !$past(pn[1], 3)) else $error("sync");
    irq_src_a: assert property (irq_o |-> |irq_pending_o)
        else $error("irq source");
    stop_wake_a: assert property ((!pn[0] && mode_valid_o)[*6]
        ##0 stop_standby_i |-> stop_wake_o) else $error("wake");
    wake_cause_a: assert property (stop_wake_o |-> stop_standby_i
        && mode_valid_o) else $error("wake cause");
    cover property ($rose(mode_valid_o));
    cover property (irq_o);
    cover property (stop_wake_o);
endmodule
bind bmirq_top bmirq_properties u_props (.*);

// >>> dv/bmirq_bench.sv
`timescale 1ns/10ps
module bmirq_bench;
    import bmirq_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, stop_standby_i = 1'b0;
    logic [3:0] irq_mask_i = 4'hF, irq_edge_mode_i = 4'h0, irq_ack_i = 4'h0;
    logic [3:0] low = 4'h0, pn, operating_mode_register_o, irq_pending_o;
    logic mode_valid_o, irq_o, stop_wake_o, core_reset_n_o;
    logic [PHASE_W-1:0] phase_o;
    int n_mismatch = 0, checked = 0;
    always #20 clk_i = ~clk_i;
    bmirq_board u_board (.clk_i, .low_i(low), .pin_n_o(pn));
    bmirq_top dut (.*, .mode_sel0_irq0_pin_n_i(pn[0]),
        .mode_sel1_irq1_pin_n_i(pn[1]), .mode_sel2_irq2_pin_n_i(pn[2]),
        .mode_sel3_irq3_pin_n_i(pn[3]));
    task automatic chk(input logic [3:0] e, s, input string n);
        checked++;
        if (e !== s)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        for (int m = 0; m < 16; m++)
        begin
            rst_n_i = 1'b0;
            low = 4'(m);
            cyc(12);
            chk(4'h0, {mode_valid_o, core_reset_n_o, phase_o}, "held");
            rst_n_i = 1'b1;
            cyc(10);
            chk(4'(m), operating_mode_register_o, "mode");
            chk(4'hE, {mode_valid_o, core_reset_n_o, phase_o}, "run");
        end
        $display("mode test done");
        low = 4'h0;
        cyc(8);
        low = 4'h2;
        cyc(2);
        chk(4'h0, irq_pending_o, "sync");
        cyc(6);
        chk(4'h2, irq_pending_o, "level");
        chk(4'h1, {3'h0, irq_o}, "irq");
        irq_mask_i = 4'hD;
        cyc(1);
        chk(4'h0, {3'h0, irq_o}, "masked");
        irq_mask_i = 4'hF;
        $display("level test done");
        irq_edge_mode_i = 4'h1;
        stop_standby_i = 1'b1;
        low = 4'h1;
        cyc(8);
        chk(4'h1, {3'h0, stop_wake_o}, "wake");
        stop_standby_i = 1'b0;
        low = 4'h0;
        cyc(8);
        chk(4'h0, {3'h0, stop_wake_o}, "no wake");
        chk(4'h1, irq_pending_o, "edge");
        irq_ack_i = 4'h1;
        cyc(1);
        irq_ack_i = 4'h0;
        cyc(2);
        chk(4'h0, irq_pending_o, "ack");
        $display("edge test done");
        end_sim();
    end
    initial
    begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
